// [hw/acp_pkg.sv]
// package: encodings, register map and carriers for the bus address port
`default_nettype none
package acp_pkg;
  // ==========================================================
  // transfer size codes on the access_size field
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;

  // ==========================================================
  // register offsets (byte addresses) and bit positions
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_CNT = 4'h8;
  localparam int CTRL_COMP_BIT = 0;
  localparam int CTRL_PRIV_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam logic CTRL_COMP_RST = 1'b0;
  localparam logic CTRL_PRIV_RST = 1'b1;

  // ==========================================================
  // request kinds and sequencer states
  typedef enum logic [1:0] {OP_XFER, OP_INTERNAL, OP_COPROC, OP_SWAP} acp_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_MERGE, ST_SWAPW} acp_st_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    acp_op_e op;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [3:0] beats;
    logic merged;
    logic data_xfer;
  } acp_req_s;

  typedef struct packed {
    logic [31:0] addr;
    logic write_not_read;
    logic [1:0] access_size;
    logic data_not_fetch;
    logic privileged_access;
    logic atomic_hold;
  } acp_addr_s;

  typedef struct packed {
    logic memory_request_low;
    logic burst_continue_flag;
  } acp_cyc_s;

  localparam acp_cyc_s CYC_N = '{memory_request_low: 1'b0, burst_continue_flag: 1'b0};
  localparam acp_cyc_s CYC_S = '{memory_request_low: 1'b0, burst_continue_flag: 1'b1};
  localparam acp_cyc_s CYC_I = '{memory_request_low: 1'b1, burst_continue_flag: 1'b0};
  localparam acp_cyc_s CYC_C = '{memory_request_low: 1'b1, burst_continue_flag: 1'b1};
  localparam acp_addr_s ADDR_RST = '{addr: 32'h0, write_not_read: 1'b0, access_size: SZ_WORD,
                                     data_not_fetch: 1'b0, privileged_access: 1'b1, atomic_hold: 1'b0};

  // byte step of one beat for a given size
  function automatic logic [31:0] acp_step(input logic [1:0] size);
    logic [31:0] s;
    s = 32'h1;
    if (size == SZ_HALF) begin
      s = 32'h2;
    end else if (size == SZ_WORD) begin
      s = 32'h4;
    end
    return s;
  endfunction
endpackage
`default_nettype wire

// [hw/acp_align.sv]
// alignment and size legality check for one requested transfer
`default_nettype none
module acp_align (
  input wire logic [1:0] i_size,
  input wire logic [1:0] i_addr_lo,
  input wire logic [3:0] i_beats,
  output logic o_ok
);
  logic aligned;
  logic burst;

  // natural boundary check, reserved size and byte bursts refused
  always_comb begin
    aligned = 1'b1;
    if (i_size == acp_pkg::SZ_WORD) begin
      aligned = (i_addr_lo == 2'h0);
    end else if (i_size == acp_pkg::SZ_HALF) begin
      aligned = ~i_addr_lo[0];
    end
    burst = (i_beats > 4'h1);
    o_ok = aligned && (i_size != acp_pkg::SZ_RSVD) && !(burst && i_size == acp_pkg::SZ_BYTE);
  end
endmodule
`default_nettype wire

// [hw/acp_top.sv]
// address-side bus cycle generator with pipelined or depipelined address timing
//
// Design decisions made here: the strobed register port and the register offsets.
`default_nettype none
module acp_top #(
  parameter int CNT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire acp_pkg::acp_req_s i_req,
  output logic o_req_ready,
  input wire logic i_address_pipeline_select,
  output acp_pkg::acp_cyc_s o_cyc,
  output acp_pkg::acp_addr_s o_addr,
  output logic o_instruction_state_flag,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  // ==========================================================
  // state record
  typedef struct packed {
    acp_pkg::acp_st_e st;
    logic [3:0] left;
    logic ready;
    acp_pkg::acp_cyc_s cyc;
    acp_pkg::acp_addr_s beat;
    acp_pkg::acp_addr_s out;
    logic comp;
    logic priv;
    logic err;
    logic [CNT_W-1:0] cnt;
    logic [31:0] rdata;
  } acp_state_s;

  acp_state_s q;
  acp_state_s d;
  logic req_ok;
  logic [3:0] chk_beats;
  logic take;
  logic err_set;

  // ==========================================================
  // request check; a swap is always a single read and a single write
  assign chk_beats = (i_req.op == acp_pkg::OP_SWAP) ? 4'h1 : i_req.beats;
  assign take = i_req.valid && q.ready;

  acp_align u_align (
    .i_size(i_req.size),
    .i_addr_lo(i_req.addr[1:0]),
    .i_beats(chk_beats),
    .o_ok(req_ok)
  );

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    err_set = 1'b0;
    d.cyc = acp_pkg::CYC_I;
    d.beat.atomic_hold = 1'b0;
    case (q.st)
      acp_pkg::ST_IDLE: begin
        if (take) begin
          d.beat.addr = i_req.addr;
          d.beat.write_not_read = i_req.write;
          d.beat.access_size = i_req.size;
          d.beat.data_not_fetch = i_req.data_xfer;
          d.beat.privileged_access = q.priv;
          case (i_req.op)
            acp_pkg::OP_INTERNAL: begin
              d.cyc = acp_pkg::CYC_I;
            end
            acp_pkg::OP_COPROC: begin
              d.cyc = acp_pkg::CYC_C;
            end
            acp_pkg::OP_SWAP: begin
              if (req_ok) begin
                d.cyc = acp_pkg::CYC_N;
                d.beat.write_not_read = 1'b0;
                d.beat.atomic_hold = 1'b1;
                d.st = acp_pkg::ST_SWAPW;
              end else begin
                // refused: the bus keeps the last accepted attributes, which an internal or coprocessor request loads unchecked
                d.beat = q.beat;
                d.beat.atomic_hold = 1'b0;
                d.err = 1'b1;
                err_set = 1'b1;
              end
            end
            default: begin
              if (!req_ok) begin
                d.beat = q.beat;
                d.beat.atomic_hold = 1'b0;
                d.err = 1'b1;
                err_set = 1'b1;
              end else if (i_req.merged) begin
                d.cyc = acp_pkg::CYC_I;
                d.st = acp_pkg::ST_MERGE;
                d.left = i_req.beats;
              end else begin
                d.cyc = acp_pkg::CYC_N;
                if (i_req.beats > 4'h1) begin
                  d.st = acp_pkg::ST_BURST;
                  d.left = i_req.beats - 4'h1;
                end
              end
            end
          endcase
        end
      end
      acp_pkg::ST_BURST: begin
        d.cyc = acp_pkg::CYC_S;
        d.beat.addr = q.beat.addr + acp_pkg::acp_step(q.beat.access_size);
        d.left = q.left - 4'h1;
        if (q.left <= 4'h1) begin
          d.st = acp_pkg::ST_IDLE;
        end
      end
      acp_pkg::ST_MERGE: begin
        d.cyc = acp_pkg::CYC_S;
        if (q.left > 4'h1) begin
          d.st = acp_pkg::ST_BURST;
          d.left = q.left - 4'h1;
        end else begin
          d.st = acp_pkg::ST_IDLE;
        end
      end
      default: begin
        d.cyc = acp_pkg::CYC_N;
        d.beat.write_not_read = 1'b1;
        d.beat.atomic_hold = 1'b1;
        d.st = acp_pkg::ST_IDLE;
      end
    endcase
    d.ready = (d.st == acp_pkg::ST_IDLE);
    // pipelined: attributes travel with the cycle type; depipelined: one cycle later
    d.out = i_address_pipeline_select ? d.beat : q.beat;
    if (!d.cyc.memory_request_low) begin
      d.cnt = q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    // register writes; a refusal in the same cycle beats the clear
    if (i_reg_wr) begin
      if (i_reg_addr == acp_pkg::OFS_CTRL) begin
        d.comp = i_reg_wdata[acp_pkg::CTRL_COMP_BIT];
        d.priv = i_reg_wdata[acp_pkg::CTRL_PRIV_BIT];
      end else if (i_reg_addr == acp_pkg::OFS_STAT) begin
        if (i_reg_wdata[acp_pkg::STAT_ERR_BIT] && !err_set) begin
          d.err = 1'b0;
        end
      end else if (i_reg_addr == acp_pkg::OFS_CNT) begin
        d.cnt = '0;
      end
    end
    // register reads, answered one cycle later
    d.rdata = 32'h0;
    if (i_reg_rd) begin
      if (i_reg_addr == acp_pkg::OFS_CTRL) begin
        d.rdata[acp_pkg::CTRL_COMP_BIT] = q.comp;
        d.rdata[acp_pkg::CTRL_PRIV_BIT] = q.priv;
      end else if (i_reg_addr == acp_pkg::OFS_STAT) begin
        d.rdata[acp_pkg::STAT_BUSY_BIT] = (q.st != acp_pkg::ST_IDLE);
        d.rdata[acp_pkg::STAT_ERR_BIT] = q.err;
      end else if (i_reg_addr == acp_pkg::OFS_CNT) begin
        d.rdata[CNT_W-1:0] = q.cnt;
      end
    end
  end

  // ==========================================================
  // state register, synchronous reset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q.st <= acp_pkg::ST_IDLE;
      q.left <= 4'h0;
      q.ready <= 1'b1;
      q.cyc <= acp_pkg::CYC_I;
      q.beat <= acp_pkg::ADDR_RST;
      q.out <= acp_pkg::ADDR_RST;
      q.comp <= acp_pkg::CTRL_COMP_RST;
      q.priv <= acp_pkg::CTRL_PRIV_RST;
      q.err <= 1'b0;
      q.cnt <= '0;
      q.rdata <= 32'h0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state record
  assign o_req_ready = q.ready;
  assign o_cyc = q.cyc;
  assign o_addr = q.out;
  assign o_instruction_state_flag = q.comp;
  assign o_reg_rdata = q.rdata;
endmodule
`default_nettype wire

// [sim/acp_checker.sv]
// checker: cycle type and address-class relations at the port
`default_nettype none
module acp_checker #(
  parameter int CNT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic o_req_ready,
  input wire logic i_address_pipeline_select,
  input wire acp_pkg::acp_cyc_s o_cyc,
  input wire acp_pkg::acp_addr_s o_addr
);
  // ==========================================================
  // helpers: pipelined timing over two edges, memory cycle kinds
  logic sel_q;
  wire logic pl = i_address_pipeline_select & sel_q;
  wire logic ns = !o_cyc.memory_request_low;
  wire logic sq = ns & o_cyc.burst_continue_flag;
  always_ff @(posedge i_mclk) begin
    sel_q <= i_address_pipeline_select;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // assertions
  AST_NO_RSVD: assert property (ns |-> o_addr.access_size != 2'h3)
    else $error("reserved size on a memory cycle");
  AST_ALIGN: assert property (pl && ns |-> !(o_addr.access_size == 2'h2 && o_addr.addr[1:0] != 2'h0)
    && !(o_addr.access_size == 2'h1 && o_addr.addr[0])) else $error("misaligned transfer");
  AST_STEP: assert property (pl && sq && $past(ns) |-> o_addr.addr == $past(o_addr.addr)
    + ((o_addr.access_size == 2'h2) ? 32'h4 : 32'h2)) else $error("burst address step wrong");
  AST_DIR: assert property (pl && sq |-> $stable(o_addr.write_not_read))
    else $error("direction changed in burst");
  AST_SIZE: assert property (pl && sq |-> o_addr.access_size != 2'h0 && $stable(o_addr.access_size))
    else $error("size changed in burst or byte burst");
  AST_MERGE: assert property (pl && sq && $past(o_cyc) == 2'h2 |-> $stable(o_addr.addr))
    else $error("merged sequential address differs");
  AST_LOCK: assert property (pl && ns && o_addr.atomic_hold && !o_addr.write_not_read |=>
    ns && o_addr.write_not_read && o_addr.atomic_hold && $stable(o_addr.addr)) else $error("swap pair broken");
  AST_UNLOCK: assert property (pl && ns && o_addr.atomic_hold && o_addr.write_not_read |=>
    !o_addr.atomic_hold) else $error("atomic hold stuck after swap");
  cover property (pl && sq && $past(o_cyc) == 2'h2);
  cover property (o_addr.atomic_hold);
  cover property (!o_req_ready);
endmodule
bind acp_top acp_checker #(.CNT_W(CNT_W)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .o_req_ready(o_req_ready),
  .i_address_pipeline_select(i_address_pipeline_select), .o_cyc(o_cyc), .o_addr(o_addr));
`default_nettype wire

// [sim/acp_mem_model.sv]
// partner: memory controller that commits only on N and S cycles
`default_nettype none
module acp_mem_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire acp_pkg::acp_cyc_s i_cyc,
  input wire acp_pkg::acp_addr_s i_addr,
  output int o_n_acc,
  output acp_pkg::acp_addr_s o_last,
  output logic [3:0] o_last_be
);
  logic [3:0] be;

  // ==========================================================
  // byte lanes touched; bits below the access size are ignored
  always_comb begin
    be = 4'hf;
    if (i_addr.access_size == acp_pkg::SZ_BYTE) begin
      be = 4'h1 << i_addr.addr[1:0];
    end else if (i_addr.access_size == acp_pkg::SZ_HALF) begin
      be = i_addr.addr[1] ? 4'hc : 4'h3;
    end
  end

  // ==========================================================
  // count committed accesses, ignore I and C cycles
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_n_acc <= 0;
    end else if (!i_cyc.memory_request_low) begin
      o_n_acc <= o_n_acc + 1;
      o_last <= i_addr;
      o_last_be <= be;
    end
  end
endmodule
`default_nettype wire

// [sim/acp_top_tb.sv]
// testbench: request table, register bus and address timing
`default_nettype none
module acp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    acp_pkg::acp_req_s r;
    logic [3:0] n;
    logic [31:0] a;
    logic w;
    logic [3:0] be;
  } acp_row_s;
  logic i_mclk = 0;
  logic i_rst = 1;
  logic sel = 1;
  logic [3:0] lbe;
  logic wr = 0;
  logic rd = 0;
  logic [3:0] ra = 0;
  logic [31:0] wd = 0;
  logic rdy, flag;
  logic [31:0] rdat;
  acp_pkg::acp_req_s req = '0;
  acp_pkg::acp_cyc_s cyc;
  acp_pkg::acp_addr_s adr, last;
  int nacc, c0, n_fail = 0, samples_checked = 0;
  acp_row_s tab[11];
  acp_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .o_req_ready(rdy),
    .i_address_pipeline_select(sel), .o_cyc(cyc), .o_addr(adr), .o_instruction_state_flag(flag),
    .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat));
  acp_mem_model mem (.i_mclk(i_mclk), .i_rst(i_rst), .i_cyc(cyc), .i_addr(adr), .o_n_acc(nacc), .o_last(last),
    .o_last_be(lbe));
  // ==========================================================
  // helpers
  function automatic acp_pkg::acp_req_s mk(input logic [1:0] op, input logic w, input logic [1:0] s,
    input logic [31:0] a, input logic [3:0] b, input logic m, input logic d);
    return '{1'b1, acp_pkg::acp_op_e'(op), w, s, a, b, m, d};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic go(input acp_pkg::acp_req_s r);
    @(posedge i_mclk);
    req <= r;
    @(posedge i_mclk);
    req.valid <= 1'b0;
    #1;
  endtask
  // register write (w=1) or read compared against d
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    ra <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge i_mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w) chk(rdat, d);
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    int k;
    tab[0] = '{mk(0, 0, 2, 'h100, 3, 0, 1), 3, 'h108, 0, 4'hf};
    tab[1] = '{mk(0, 1, 1, 'h202, 2, 0, 1), 2, 'h204, 1, 4'h3};
    tab[2] = '{mk(0, 0, 1, 'h310, 2, 0, 0), 2, 'h312, 0, 4'hc};
    tab[3] = '{mk(0, 1, 0, 'h303, 1, 0, 1), 1, 'h303, 1, 4'h8};
    tab[4] = '{mk(1, 0, 2, 'h700, 1, 0, 1), 0, 0, 0, 4'h0};
    tab[5] = '{mk(2, 0, 2, 'h0, 1, 0, 1), 0, 0, 0, 4'h0};
    tab[6] = '{mk(0, 0, 2, 'h400, 2, 1, 1), 2, 'h404, 0, 4'hf};
    tab[7] = '{mk(3, 0, 2, 'h500, 0, 0, 1), 2, 'h500, 1, 4'hf};
    tab[8] = '{mk(0, 0, 2, 'h102, 1, 0, 1), 0, 0, 0, 4'h0};
    tab[9] = '{mk(0, 0, 0, 'h10, 2, 0, 1), 0, 0, 0, 4'h0};
    tab[10] = '{mk(0, 0, 3, 'h10, 1, 0, 1), 0, 0, 0, 4'h0};
    repeat (11) @(posedge i_mclk);
    #1;
    chk(cyc, 2'h2);
    @(posedge i_mclk);
    i_rst <= 1'b0;
    foreach (tab[i]) begin
      c0 = nacc;
      go(tab[i].r);
      for (k = 0; k < 30; k++) begin
        if (rdy && cyc === acp_pkg::CYC_I) break;
        @(posedge i_mclk);
        #1;
      end
      chk(nacc - c0, tab[i].n);
      if (tab[i].n != 0) begin
        chk(last.addr, tab[i].a);
        chk({last.write_not_read, last.data_not_fetch}, {tab[i].w, tab[i].r.data_xfer});
        chk(lbe, tab[i].be);
        chk(last.access_size, tab[i].r.size);
        chk(last.atomic_hold, tab[i].r.op == acp_pkg::OP_SWAP);
        chk(last.privileged_access, 1'b1);
      end
      $display("row %0d done", i);
    end
    bus(0, acp_pkg::OFS_STAT, 32'h2);
    // refused request and error clear in one cycle: the new refusal wins
    @(posedge i_mclk);
    req <= mk(0, 0, 2, 'h1, 1, 0, 1);
    ra <= acp_pkg::OFS_STAT;
    wd <= 32'h2;
    wr <= 1'b1;
    @(posedge i_mclk);
    req.valid <= 1'b0;
    wr <= 1'b0;
    bus(0, acp_pkg::OFS_STAT, 32'h2);
    bus(1, acp_pkg::OFS_STAT, 32'h2);
    bus(0, acp_pkg::OFS_STAT, 32'h0);
    bus(0, acp_pkg::OFS_CNT, 32'hc);
    bus(0, 4'hc, 32'h0);
    bus(1, acp_pkg::OFS_CTRL, 32'h1);
    chk(flag, 1'b1);
    $display("register test done");
    @(posedge i_mclk);
    sel <= 1'b0;
    go(mk(0, 0, 2, 'h600, 1, 0, 1));
    chk(cyc, 2'h0);
    chk(adr.addr == 32'h600, 1'b0);
    @(posedge i_mclk);
    #1;
    chk(adr.addr, 32'h600);
    chk(adr.privileged_access, 1'b0);
    $display("depipelined test done");
    // reset in mid-run: outputs return to their idle values, control bits to defaults
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    chk({cyc, rdy, flag, adr.privileged_access, adr.atomic_hold}, {acp_pkg::CYC_I, 1'b1, 1'b0, 1'b1, 1'b0});
    chk(rdat, 32'h0);
    @(posedge i_mclk);
    i_rst <= 1'b0;
    bus(0, acp_pkg::OFS_CTRL, 32'h2);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
